// file: ee2w_pkg.sv
// Package for the two-wire serial byte memory: sizes, codes, timing
// Assumes a 20 MHz system clock shared by both ends
package ee2w_pkg;
    localparam int unsigned CLK_HZ              = 20_000_000;
    localparam int unsigned ADDR_W              = 8;
    localparam int unsigned DATA_W              = 8;
    localparam int unsigned PAGE_BYTES          = 16;
    localparam int unsigned PAGE_COUNT          = 16;
    localparam int unsigned MEM_BYTES           = PAGE_BYTES * PAGE_COUNT;
    localparam int unsigned OFS_W               = 4;
    // Fixed type code of the address word (value arbitrary)
    localparam logic [3:0]  TYPE_CODE           = 4'h5;
    // Internal write cycle time, microseconds, and cycle count (rounded down)
    localparam int unsigned WRITE_CYCLE_US      = 3000;
    localparam int unsigned WRITE_CYCLE_CYCLES  = (CLK_HZ / 1_000_000) * WRITE_CYCLE_US;
    // Master bus clock: half period in system cycles (10 us period)
    localparam int unsigned MST_HALF_CYCLES     = 100;
    localparam int unsigned RECOVER_CLOCKS      = 9;
    localparam logic [ADDR_W-1:0] WADDR_RESET   = 8'h00;
    typedef enum logic [2:0] {EE2W_OP_IDLE, EE2W_OP_WRITE, EE2W_OP_READ, EE2W_OP_SETADDR,
                              EE2W_OP_CURREAD, EE2W_OP_RECOVER} ee2w_op_t;
endpackage

// file: ee2w_if.sv
// Two-wire link between master and memory: clock line and open-drain data
// Assumes both lines pulled high; each end only pulls low
`timescale 1ns/1ps
interface ee2w_if;
    logic mst_scl_o;
    logic mst_scl_oe;
    logic mst_sda_o;
    logic mst_sda_oe;
    logic mem_sda_o;
    logic mem_sda_oe;
    logic scl;
    logic sda;
    // Wired-AND resolution of the open-drain lines
    assign scl = ~(mst_scl_oe & ~mst_scl_o);
    assign sda = ~(mst_sda_oe & ~mst_sda_o) & ~(mem_sda_oe & ~mem_sda_o);
    modport mem (input scl, input sda, output mem_sda_o, output mem_sda_oe);
    modport mst (input scl, input sda, output mst_scl_o, output mst_scl_oe,
                 output mst_sda_o, output mst_sda_oe);
endinterface

// file: ee2w_mem.sv
// Memory end: two-wire slave with 256-byte array and timed write cycle
// Assumes link lines arrive unsynchronised; one system clock
// Behaviour
// - sample on rising clock, drive on falling
// - protect input high at data bytes or at stop blocks array writes; not checked once programming runs
// - sixteen pages of sixteen, 8-bit address
// - data changes only while clock low
// - start restarts protocol state
// - stop after read enters standby
// - acknowledge each received byte on ninth clock
// - standby at power-up and after stop
// - master recovers with nine clocks, start
// - address word holds type code, straps
// - floating straps read as zero
// - address bit zero selects read or write
// - acknowledge match, otherwise standby
// - byte write ends with stop, starts programming
// - ignore bus during programming, bounded time
// - page write acknowledges every byte; page buffer keeps sixteen
// - write increments only within page, wraps
// - no address acknowledge while programming
// - address counter is last plus one
// - current read sends counter byte
// - random read uses dummy write, restart
// - sequential read continues, wraps whole array
`timescale 1ns/1ps
module ee2w_mem (
    input  wire logic           i_clk_sys,
    input  wire logic           i_rst,
    input  wire logic [2:0]     i_chip_select_straps,
    input  wire logic           i_write_protect,
    output logic                o_busy,
    ee2w_if.mem                 link
);
    import ee2w_pkg::*;

    typedef enum {EE2W_S_IDLE, EE2W_S_DEV, EE2W_S_WADDR, EE2W_S_WDATA, EE2W_S_RDATA,
                  EE2W_S_IGNORE} ee2w_state_t;

    logic [7:0]              mem_q [MEM_BYTES];
    logic [2:0]              scl_sync_q;
    logic [2:0]              sda_sync_q;
    logic                    scl_q;
    logic                    sda_q;
    ee2w_state_t             state_q;
    logic [3:0]              bit_q;
    logic [7:0]              shift_q;
    logic [ADDR_W-1:0]       waddr_q;
    logic [7:0]              page_buf_q [PAGE_BYTES];
    logic [PAGE_BYTES-1:0]   page_vld_q;
    logic                    ack_pend_q;
    logic                    rd_ack_q;
    logic                    sda_drv_q;
    logic [21:0]             wr_cnt_q;
    logic                    prog_q;
    logic                    rise;
    logic                    fall;
    logic                    start_c;
    logic                    stop_c;
    logic                    dev_match;
    logic                    prog_go;

    // Three-stage synchronisers; filtered level needs stages two and three to agree
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
        end else begin
            scl_sync_q <= {scl_sync_q[1:0], link.scl};
            sda_sync_q <= {sda_sync_q[1:0], link.sda};
        end
    end

    // Filtered line levels
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            if (scl_sync_q[1] == scl_sync_q[2]) scl_q <= scl_sync_q[2];
            if (sda_sync_q[1] == sda_sync_q[2]) sda_q <= sda_sync_q[2];
        end
    end

    // Edge and condition detection
    assign rise    = ~scl_q & scl_sync_q[2] & scl_sync_q[1];
    assign fall    = scl_q & ~scl_sync_q[2] & ~scl_sync_q[1];
    assign start_c = scl_q & sda_q & ~sda_sync_q[2] & ~sda_sync_q[1];
    assign stop_c  = scl_q & ~sda_q & sda_sync_q[2] & sda_sync_q[1];
    // Unconnected straps are pulled low by the pad, so they compare as zero
    assign dev_match = (shift_q[7:4] == TYPE_CODE) && (shift_q[3:1] == i_chip_select_straps);
    assign prog_go = stop_c && (state_q == EE2W_S_WDATA) && (page_vld_q != '0)
                     && !i_write_protect;

    // Timed programming cycle
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            prog_q   <= 1'b0;
            wr_cnt_q <= '0;
        end else if (prog_go) begin
            prog_q   <= 1'b1;
            wr_cnt_q <= 22'(WRITE_CYCLE_CYCLES - 1);
        end else if (prog_q) begin
            if (wr_cnt_q == '0) prog_q <= 1'b0;
            else wr_cnt_q <= wr_cnt_q - 22'h0001;
        end
    end
    assign o_busy = prog_q;

    // Array commit at the end of programming
    always_ff @(posedge i_clk_sys) begin
        if (prog_q && wr_cnt_q == '0) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (page_vld_q[i]) mem_q[{waddr_q[7:4], 4'(i)}] <= page_buf_q[i];
            end
        end
    end

    // Protocol engine
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state_q    <= EE2W_S_IDLE;
            bit_q      <= '0;
            shift_q    <= '0;
            waddr_q    <= WADDR_RESET;
            page_vld_q <= '0;
            ack_pend_q <= 1'b0;
            rd_ack_q   <= 1'b0;
            sda_drv_q  <= 1'b0;
        end else if (prog_q) begin
            state_q   <= EE2W_S_IDLE;
            sda_drv_q <= 1'b0;
            if (wr_cnt_q == '0) page_vld_q <= '0;
        end else if (start_c) begin
            state_q    <= EE2W_S_DEV;
            bit_q      <= '0;
            ack_pend_q <= 1'b0;
            sda_drv_q  <= 1'b0;
        end else if (stop_c) begin
            if (!prog_go) page_vld_q <= '0;
            state_q   <= EE2W_S_IDLE;
            sda_drv_q <= 1'b0;
        end else if (state_q == EE2W_S_IDLE || state_q == EE2W_S_IGNORE) begin
            sda_drv_q <= 1'b0;
        end else if (rise) begin
            // Sample the line on the rising clock edge
            if (bit_q < 4'd8) begin
                // Outgoing read byte keeps its value; only received words shift in
                if (state_q != EE2W_S_RDATA) shift_q <= {shift_q[6:0], sda_q};
                bit_q   <= bit_q + 4'd1;
            end else begin
                bit_q <= '0;
                if (state_q == EE2W_S_RDATA) rd_ack_q <= ~sda_q;
            end
        end else if (fall) begin
            // Drive the line only after the falling clock edge
            if (bit_q == 4'd8 && !ack_pend_q && state_q != EE2W_S_RDATA) begin
                ack_pend_q <= 1'b1;
                unique case (state_q)
                    EE2W_S_DEV: begin
                        if (dev_match) sda_drv_q <= 1'b1;
                        else state_q <= EE2W_S_IGNORE;
                    end
                    EE2W_S_WADDR: begin
                        waddr_q    <= shift_q;
                        page_vld_q <= '0;
                        sda_drv_q  <= 1'b1;
                        state_q    <= EE2W_S_WDATA;
                    end
                    EE2W_S_WDATA: begin
                        if (!i_write_protect) begin
                            page_buf_q[waddr_q[3:0]] <= shift_q;
                            page_vld_q[waddr_q[3:0]] <= 1'b1;
                        end
                        waddr_q   <= {waddr_q[7:4], waddr_q[3:0] + 4'h1};
                        sda_drv_q <= 1'b1;
                    end
                    default: sda_drv_q <= 1'b0;
                endcase
            end else if (bit_q == 4'd0 && ack_pend_q) begin
                // End of acknowledge slot: release, or open a read
                ack_pend_q <= 1'b0;
                sda_drv_q  <= 1'b0;
                if (state_q == EE2W_S_DEV) begin
                    if (shift_q[0]) begin
                        state_q   <= EE2W_S_RDATA;
                        shift_q   <= mem_q[waddr_q];
                        waddr_q   <= waddr_q + 8'h01;
                        sda_drv_q <= ~mem_q[waddr_q][7];
                    end else begin
                        state_q <= EE2W_S_WADDR;
                    end
                end
            end else if (state_q == EE2W_S_RDATA) begin
                if (bit_q < 4'd8) begin
                    sda_drv_q <= ~shift_q[7 - 3'(bit_q)] && bit_q != 4'd0;
                end else if (bit_q == 4'd8) begin
                    sda_drv_q <= 1'b0;
                end
                if (bit_q == 4'd0 && rd_ack_q) begin
                    rd_ack_q  <= 1'b0;
                    shift_q   <= mem_q[waddr_q];
                    waddr_q   <= waddr_q + 8'h01;
                    sda_drv_q <= ~mem_q[waddr_q][7];
                end else if (bit_q == 4'd0) begin
                    state_q <= EE2W_S_IGNORE;
                end
            end
        end
    end

    // Open-drain data pin: drive low only
    assign link.mem_sda_o  = 1'b0;
    assign link.mem_sda_oe = sda_drv_q;
endmodule

// file: ee2w_mst.sv
// Master end: generates bus clock and runs write, read and recovery commands
// Assumes one command at a time on the user port; memory end on the same link
`timescale 1ns/1ps
module ee2w_mst (
    input  wire logic            i_clk_sys,
    input  wire logic            i_rst,
    input  wire logic            i_cmd_valid,
    input  ee2w_pkg::ee2w_op_t   i_cmd_op,
    input  wire logic [2:0]      i_cmd_straps,
    input  wire logic [7:0]      i_cmd_addr,
    input  wire logic [7:0]      i_cmd_data,
    output logic                 o_cmd_ready,
    output logic                 o_done,
    output logic                 o_nack,
    output logic [7:0]           o_rd_data,
    ee2w_if.mst                  link
);
    import ee2w_pkg::*;

    typedef enum {EE2W_M_IDLE, EE2W_M_START, EE2W_M_BIT, EE2W_M_STOP, EE2W_M_DONE} ee2w_mstate_t;

    ee2w_mstate_t  state_q;
    ee2w_op_t      op_q;
    logic [7:0]    div_q;
    logic [1:0]    ph_q;
    logic [3:0]    bit_q;
    logic [1:0]    byte_q;
    logic [8:0]    tx_q;
    logic [7:0]    rx_q;
    logic          scl_q;
    logic          sda_q;
    logic          nack_q;
    logic          tick;
    logic [2:0]    sda_sync_q;
    logic          sda_in_q;
    logic          own_ack;

    // Quarter-period enable pulse from the divider
    assign tick = (div_q == 8'((MST_HALF_CYCLES / 2) - 1));
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) div_q <= '0;
        else div_q <= tick ? 8'h00 : div_q + 8'h01;
    end

    // Three-stage synchroniser on the shared data line; stages two and three must agree
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sda_sync_q <= 3'h7;
            sda_in_q   <= 1'b1;
        end else begin
            sda_sync_q <= {sda_sync_q[1:0], link.sda};
            if (sda_sync_q[1] == sda_sync_q[2]) sda_in_q <= sda_sync_q[2];
        end
    end

    // Ack slot that belongs to the master itself: last byte of a read
    assign own_ack = (op_q == EE2W_OP_READ && byte_q == 2'd3) || (op_q == EE2W_OP_CURREAD && byte_q == 2'd1);

    // Frame byte for the given step of the command
    function automatic logic [8:0] frame_byte(input ee2w_op_t op, input logic [1:0] idx,
                                              input logic [2:0] cs, input logic [7:0] a,
                                              input logic [7:0] d);
        logic rd;
        rd = (op == EE2W_OP_CURREAD) || (op == EE2W_OP_READ && idx == 2'd2);
        if (idx == 2'd0 || (op == EE2W_OP_READ && idx == 2'd2)) frame_byte = {TYPE_CODE, cs, rd, 1'b1};
        else if (idx == 2'd1) frame_byte = {a, 1'b1};
        else if (op == EE2W_OP_READ) frame_byte = {8'hFF, 1'b1};
        else frame_byte = {d, 1'b1};
    endfunction

    // Command sequencer: ph 0..3 is low, low, high, high of one bus clock
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state_q <= EE2W_M_IDLE;
            op_q    <= EE2W_OP_IDLE;
            ph_q    <= '0;
            bit_q   <= '0;
            byte_q  <= '0;
            tx_q    <= '1;
            rx_q    <= '0;
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
            nack_q  <= 1'b0;
            o_done  <= 1'b0;
            o_nack  <= 1'b0;
            o_rd_data <= '0;
        end else begin
            o_done <= 1'b0;
            unique case (state_q)
                EE2W_M_IDLE: if (i_cmd_valid) begin
                    op_q    <= i_cmd_op;
                    byte_q  <= '0;
                    nack_q  <= 1'b0;
                    ph_q    <= '0;
                    bit_q   <= '0;
                    tx_q    <= (i_cmd_op == EE2W_OP_RECOVER) ? 9'h1FF
                              : frame_byte(i_cmd_op, 2'd0, i_cmd_straps, i_cmd_addr, i_cmd_data);
                    state_q <= (i_cmd_op == EE2W_OP_RECOVER) ? EE2W_M_BIT : EE2W_M_START;
                end
                EE2W_M_START: if (tick) begin
                    ph_q <= ph_q + 2'd1;
                    if (ph_q == 2'd0) begin
                        sda_q <= 1'b1;
                        scl_q <= 1'b1;
                    end
                    if (ph_q == 2'd2) sda_q <= 1'b0;
                    if (ph_q == 2'd3) begin
                        scl_q   <= 1'b0;
                        state_q <= EE2W_M_BIT;
                    end
                end
                EE2W_M_BIT: if (tick) begin
                    ph_q <= ph_q + 2'd1;
                    if (ph_q == 2'd0) begin
                        // Read bytes and the memory's ack slots leave the line released
                        sda_q <= tx_q[8];
                    end
                    if (ph_q == 2'd1) scl_q <= 1'b1;
                    if (ph_q == 2'd2) begin
                        // Ack slot is not data
                        if (bit_q != 4'd8) rx_q <= {rx_q[6:0], sda_in_q};
                        if (bit_q == 4'd8 && sda_in_q && op_q != EE2W_OP_RECOVER
                            && !own_ack) nack_q <= 1'b1;
                    end
                    if (ph_q == 2'd3) begin
                        scl_q <= 1'b0;
                        tx_q  <= {tx_q[7:0], 1'b1};
                        bit_q <= bit_q + 4'd1;
                        if (bit_q == 4'd8) begin
                            bit_q  <= '0;
                            byte_q <= byte_q + 2'd1;
                            if (op_q == EE2W_OP_RECOVER) state_q <= EE2W_M_START;
                            else if (nack_q || sda_in_q && !own_ack)
                                state_q <= EE2W_M_STOP;
                            else if (op_q == EE2W_OP_CURREAD && byte_q == 2'd0) begin
                                tx_q <= 9'h1FF;                          // no ack
                            end else if ((op_q == EE2W_OP_CURREAD && byte_q == 2'd1)
                                         || (op_q == EE2W_OP_SETADDR && byte_q == 2'd1)
                                         || (op_q == EE2W_OP_WRITE && byte_q == 2'd2)
                                         || (op_q == EE2W_OP_READ && byte_q == 2'd3)) begin
                                state_q <= EE2W_M_STOP;
                            end else if (op_q == EE2W_OP_READ && byte_q == 2'd1) begin
                                tx_q    <= frame_byte(op_q, 2'd2, i_cmd_straps, i_cmd_addr, i_cmd_data);
                                state_q <= EE2W_M_START;
                            end else begin
                                tx_q <= frame_byte(op_q, byte_q + 2'd1, i_cmd_straps, i_cmd_addr, i_cmd_data);
                            end
                        end
                    end
                    if (op_q == EE2W_OP_RECOVER && byte_q == 2'd1 && ph_q == 2'd3) state_q <= EE2W_M_DONE;
                end
                EE2W_M_STOP: if (tick) begin
                    ph_q <= ph_q + 2'd1;
                    if (ph_q == 2'd0) sda_q <= 1'b0;
                    if (ph_q == 2'd1) scl_q <= 1'b1;
                    if (ph_q == 2'd3) begin
                        sda_q   <= 1'b1;
                        state_q <= EE2W_M_DONE;
                    end
                end
                EE2W_M_DONE: begin
                    o_done  <= 1'b1;
                    o_nack  <= nack_q;
                    if (op_q == EE2W_OP_READ || op_q == EE2W_OP_CURREAD) o_rd_data <= rx_q;
                    state_q <= EE2W_M_IDLE;
                end
                default: state_q <= EE2W_M_IDLE;
            endcase
        end
    end

    assign o_cmd_ready = (state_q == EE2W_M_IDLE);
    // Open-drain drive: enable only when pulling low
    assign link.mst_scl_o  = 1'b0;
    assign link.mst_scl_oe = ~scl_q;
    assign link.mst_sda_o  = 1'b0;
    assign link.mst_sda_oe = ~sda_q;
endmodule

// file: ee2w_link_monitor.sv
// Checker for the two-wire link between the master and memory ends
// Assumes the interface signals plus the system clock and reset of the bench
`timescale 1ns/1ps
module ee2w_link_monitor (
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic mst_scl_o,
    input  wire logic mst_scl_oe,
    input  wire logic mst_sda_o,
    input  wire logic mst_sda_oe,
    input  wire logic mem_sda_o,
    input  wire logic mem_sda_oe,
    input  wire logic scl,
    input  wire logic sda
);
    logic       scl_p_q, sda_p_q, rw_q, ignore_q;
    logic [3:0] bit_q, byte_q;
    logic       start, stop, high;
    // Line conditions against the previous sample
    assign start = scl & scl_p_q & sda_p_q & ~sda;
    assign stop  = scl & scl_p_q & ~sda_p_q & sda;
    assign high  = scl & scl_p_q;
    // Bit and byte position within a frame
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            {scl_p_q, sda_p_q} <= 2'b11;
            {bit_q, byte_q} <= 8'h00;
        end else begin
            {scl_p_q, sda_p_q} <= {scl, sda};
            if (start) begin
                {bit_q, byte_q} <= 8'h00;
            end else if (scl & ~scl_p_q) begin
                bit_q  <= (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
                byte_q <= (bit_q == 4'h9 && byte_q != 4'hf) ? byte_q + 4'h1 : byte_q;
            end
        end
    end
    // Direction bit and refused-address state
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            {rw_q, ignore_q} <= 2'b00;
        end else begin
            rw_q     <= (high && byte_q == 4'h0 && bit_q == 4'h8) ? sda : rw_q;
            ignore_q <= start ? 1'b0 : (high && byte_q == 4'h0 && bit_q == 4'h9 && sda) ? 1'b1 : ignore_q;
        end
    end
    AST_MEM_CHANGE_SCL_LOW: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $changed(mem_sda_oe) |-> !scl) else $error("memory data changed while clock high");
    AST_MEM_PULLS_LOW: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        mem_sda_oe |-> !mem_sda_o) else $error("memory drives data line high");
    AST_START_RELEASE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        start |=> !mem_sda_oe [*8]) else $error("memory drives data after start");
    AST_STOP_RELEASE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        stop |=> !mem_sda_oe [*8]) else $error("memory drives data after stop");
    AST_ADDR_LISTEN: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        high && byte_q == 4'h0 && bit_q inside {[4'h1:4'h8]} |-> !mem_sda_oe)
        else $error("memory drives data during address word");
    AST_MISMATCH_QUIET: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        ignore_q |-> !mem_sda_oe) else $error("memory drives data after refused address");
    AST_ACK_NINTH: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        high && mem_sda_oe |-> bit_q == 4'h9 || (rw_q && byte_q != 4'h0))
        else $error("memory pulls data outside ninth bit");
    AST_READ_ACK_FREE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        high && rw_q && byte_q != 4'h0 && bit_q == 4'h9 |-> !mem_sda_oe)
        else $error("memory holds data during master acknowledge");
endmodule

// file: tb.sv
// Bench joining master and memory ends over one link, random data, fixed seed
// Assumes the design files and the link checker compiled first
`timescale 1ns/1ps
module tb;
    import ee2w_pkg::*;
    logic       i_clk_sys, i_rst, i_write_protect, i_cmd_valid, o_busy, o_cmd_ready, o_done, o_nack;
    logic [2:0] straps, i_cmd_straps;
    logic [7:0] i_cmd_addr, i_cmd_data, o_rd_data, addr, data;
    ee2w_op_t   i_cmd_op;
    int         miscompares, checks_done, seed, tmp, n;
    ee2w_if i_ee2w_if ();
    ee2w_mem i_ee2w_mem (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_chip_select_straps(straps),
        .i_write_protect(i_write_protect), .o_busy(o_busy), .link(i_ee2w_if.mem));
    ee2w_mst i_ee2w_mst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
        .i_cmd_straps(i_cmd_straps), .i_cmd_addr(i_cmd_addr), .i_cmd_data(i_cmd_data),
        .o_cmd_ready(o_cmd_ready), .o_done(o_done), .o_nack(o_nack), .o_rd_data(o_rd_data), .link(i_ee2w_if.mst));
    ee2w_link_monitor i_ee2w_link_monitor (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .mst_scl_o(i_ee2w_if.mst_scl_o), .mst_scl_oe(i_ee2w_if.mst_scl_oe), .mst_sda_o(i_ee2w_if.mst_sda_o),
        .mst_sda_oe(i_ee2w_if.mst_sda_oe), .mem_sda_o(i_ee2w_if.mem_sda_o), .mem_sda_oe(i_ee2w_if.mem_sda_oe),
        .scl(i_ee2w_if.scl), .sda(i_ee2w_if.sda));
    // System clock, 50 ns period
    always #25 i_clk_sys = ~i_clk_sys;
    task automatic chk_bit(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Expected refusal: wrong straps or programming in progress
    function automatic logic exp_nack(input logic [2:0] cs, input logic prog);
        return (cs !== straps) || prog;
    endfunction
    // One command: valid for one cycle, fields kept, then wait for the done pulse
    task automatic run_cmd(input ee2w_op_t op, input logic [2:0] cs, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(negedge i_clk_sys);
        i_cmd_op = op;
        i_cmd_straps = cs;
        i_cmd_addr = a;
        i_cmd_data = d;
        i_cmd_valid = 1'b1;
        @(negedge i_clk_sys);
        i_cmd_valid = 1'b0;
        k = 0;
        while (o_done !== 1'b1 && k < 20000) begin
            @(negedge i_clk_sys);
            k++;
        end
        if (k >= 20000) miscompares++;
        // Let the memory see the stop before any status is checked
        repeat (4) @(negedge i_clk_sys);
    endtask
    task automatic print_verdict();
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Watchdog beyond the longest expected run
    initial begin
        #(110_000 * 50);
        miscompares++;
        print_verdict();
    end
    // Main sequence
    initial begin
        {i_clk_sys, i_rst, i_write_protect, i_cmd_valid} = 4'b0100;
        {miscompares, checks_done, n} = '0;
        {i_cmd_straps, i_cmd_addr, i_cmd_data} = '0;
        i_cmd_op = EE2W_OP_IDLE;
        seed = 32'h1fed;
        tmp = $random(seed);
        straps = tmp[2:0];
        addr = {tmp[15:12], 4'hf}; // Page end corner
        data = tmp[23:16];
        repeat (2) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_rst = 1'b0;
        chk_bit("busy_after_reset", 1'b0, o_busy);
        run_cmd(EE2W_OP_WRITE, straps, addr, data);
        chk_bit("write_nack", exp_nack(straps, 1'b0), o_nack);
        chk_bit("busy_after_stop", 1'b1, o_busy);
        run_cmd(EE2W_OP_READ, straps, addr, 8'h00);
        chk_bit("poll_nack", exp_nack(straps, 1'b1), o_nack);
        while (o_busy === 1'b1 && n < 70000) begin
            @(negedge i_clk_sys);
            n++;
        end
        chk_bit("write_cycle_bounded", 1'b1, n <= WRITE_CYCLE_CYCLES);
        i_write_protect = 1'b1;
        run_cmd(EE2W_OP_WRITE, straps, addr, ~data);
        chk_bit("protected_nack", 1'b0, o_nack);
        chk_bit("protected_busy", 1'b0, o_busy);
        i_write_protect = 1'b0;
        run_cmd(EE2W_OP_READ, straps, addr, 8'h00);
        chk_bit("read_nack", exp_nack(straps, 1'b0), o_nack);
        chk_byte("read_data", data, o_rd_data);
        run_cmd(EE2W_OP_SETADDR, straps, addr, 8'h00);
        chk_bit("setaddr_nack", 1'b0, o_nack);
        run_cmd(EE2W_OP_CURREAD, straps, 8'h00, 8'h00);
        chk_bit("curread_nack", 1'b0, o_nack);
        chk_byte("curread_data", data, o_rd_data);
        run_cmd(EE2W_OP_READ, straps ^ 3'b001, addr, 8'h00);
        chk_bit("mismatch_nack", exp_nack(straps ^ 3'b001, 1'b0), o_nack);
        run_cmd(EE2W_OP_RECOVER, straps, 8'h00, 8'h00);
        run_cmd(EE2W_OP_READ, straps, addr, 8'h00);
        chk_byte("read_after_recover", data, o_rd_data);
        print_verdict();
    end
endmodule
